//--- inc/sleep_wake_pkg.sv
package sleep_wake_pkg;
   // bus register byte offsets
   localparam logic [7:0] off_loss_holdoff = 8'h00;
   localparam logic [7:0] off_filter = 8'h04;
   localparam logic [7:0] off_sleep_src = 8'h08;
   localparam logic [7:0] off_sleep_thr = 8'h0c;
   localparam logic [7:0] off_sleep_time = 8'h10;
   localparam logic [7:0] off_wake_thr = 8'h14;
   localparam logic [7:0] off_wake_time = 8'h18;
   localparam logic [7:0] off_safety_cfg = 8'h1c;
   localparam logic [7:0] off_comm_cfg = 8'h20;
   localparam logic [7:0] off_serial_cfg = 8'h24;
   localparam logic [7:0] off_loss_timeout = 8'h28;
   localparam logic [7:0] off_control = 8'h2c;
   localparam logic [7:0] off_status = 8'h30;
   localparam logic [7:0] off_serial_active = 8'h34;
   // reset values (times in 0.1 s, levels in 0.1 %)
   localparam logic [7:0] rst_loss_holdoff = 8'h00;
   localparam logic [3:0] rst_filter = 4'h0;
   localparam logic [1:0] rst_sleep_src = 2'h0;
   localparam logic [9:0] rst_sleep_thr = 10'h064;
   localparam logic [9:0] rst_wake_thr = 10'h096;
   localparam logic [12:0] rst_qual_time = 13'h0000;
   localparam logic [2:0] rst_bit_rate = 3'h3;
   localparam logic [7:0] rst_node_addr = 8'h64;
   localparam logic [1:0] rst_loss_action = 2'h0;
   localparam logic [2:0] rst_frame = 3'h0;
   localparam logic [9:0] rst_loss_timeout = 10'h032;
   // limits
   localparam logic [7:0] max_loss_holdoff = 8'hc8;
   localparam logic [3:0] max_filter = 4'he;
   localparam logic [9:0] max_level = 10'h3e8;
   localparam logic [12:0] max_qual_time = 13'h1770;
   localparam logic [2:0] max_bit_rate = 3'h5;
   localparam logic [7:0] min_node_addr = 8'h01;
   localparam logic [7:0] max_node_addr = 8'hf7;
   localparam logic [2:0] max_frame = 3'h5;
   localparam logic [9:0] min_loss_timeout = 10'h001;
   localparam logic [9:0] max_loss_timeout = 10'h258;
   // analog loss thresholds, 12-bit codes: 0-10 V and 0-20 mA full scale
   localparam logic [11:0] v_loss_set = 12'h199;
   localparam logic [11:0] v_loss_clr = 12'h266;
   localparam logic [11:0] i_loss_set = 12'h199;
   localparam logic [11:0] i_loss_clr = 12'h266;
   // timing
   localparam int clk_hz = 20000000;
   localparam real tick_s = 0.1;
   localparam int tick_cycles = int'(tick_s * clk_hz);
   // encodings
   localparam logic [1:0] src_off = 2'h0;
   localparam logic [1:0] src_volt = 2'h1;
   localparam logic [1:0] src_curr = 2'h2;
   localparam logic [1:0] src_freq = 2'h3;
   localparam logic [1:0] act_fault = 2'h0;
   localparam logic [1:0] act_coast = 2'h1;
   localparam logic [1:0] act_stop = 2'h2;
   localparam logic [1:0] act_continue = 2'h3;
   typedef enum logic [1:0] {st_idle, st_run, st_sleep} sleep_state_t;
endpackage

//--- design/duration_timer.sv
`timescale 1ns/1ps
// counts whole ticks while armed; zero length means done at once
module duration_timer
   import sleep_wake_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic arm_in,
   input wire logic tick_in,
   input wire logic [12:0] length_in,
   output logic done_out
);
   logic [12:0] count;

   // restart whenever disarmed, so a threshold re-cross starts over
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !arm_in) begin
         count <= 13'h0000;
      end else if (tick_in && count < length_in) begin
         count <= count + 13'h0001;
      end
   end

   assign done_out = arm_in && (count >= length_in);
endmodule

//--- design/sleep_wake_loss_supervisor.sv
`timescale 1ns/1ps
module sleep_wake_loss_supervisor
   import sleep_wake_pkg::*;
#(
   parameter int tick_len = tick_cycles
)
(
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [11:0] volt_in,
   input wire logic [11:0] curr_in,
   input wire logic [9:0] cmd_freq_pct_in,
   input wire logic [9:0] volt_pct_in,
   input wire logic [9:0] curr_pct_in,
   input wire logic running_in,
   input wire logic safety1_in,
   input wire logic safety2_in,
   input wire logic safety_hw_err_in,
   input wire logic fault_clear_in,
   input wire logic io_connected_in,
   input wire logic serial_controls_in,
   input wire logic serial_lost_in,
   output logic [11:0] volt_filt_out,
   output logic [11:0] curr_filt_out,
   output logic volt_loss_out,
   output logic curr_loss_out,
   output logic asleep_out,
   output logic force_zero_freq_out,
   output logic run_led_out,
   output logic safety_open_fault_out,
   output logic safety_hardware_fault_out,
   output logic nv_commit_out,
   output logic cmd_status_layout_out,
   output logic [15:0] bit_rate_out,
   output logic [7:0] slave_node_address_out,
   output logic parity_en_out,
   output logic parity_odd_out,
   output logic two_stop_out,
   output logic serial_fault_out,
   output logic serial_coast_out,
   output logic serial_stop_out,
   output logic serial_hold_speed_out
);
   logic [7:0] loss_holdoff_time;
   logic [3:0] input_filter_level;
   logic [1:0] sleep_source_select;
   logic [9:0] sleep_threshold;
   logic [9:0] wake_threshold;
   logic [12:0] sleep_qualify_time;
   logic [12:0] wake_qualify_time;
   logic safety_open_action;
   logic safety_fault_reset_method;
   logic param_write_mode;
   // stored bit rate, node address and frame format survive reset_in, like a nonvolatile copy; reset applies them
   logic [2:0] serial_bit_rate = rst_bit_rate;
   logic [7:0] slave_node_address = rst_node_addr;
   logic [2:0] serial_frame_format = rst_frame;
   logic [1:0] serial_loss_action;
   logic [9:0] serial_loss_timeout;
   logic [2:0] active_rate;
   logic [7:0] active_addr;
   logic [2:0] active_frame;
   logic [23:0] tick_cnt;
   logic tick;
   logic [7:0] holdoff_cnt;
   logic holdoff_done;
   logic [25:0] volt_acc;
   logic [25:0] curr_acc;
   logic [9:0] sel_pct;
   logic sleep_cond;
   logic wake_cond;
   logic sleep_done;
   logic wake_done;
   sleep_state_t state;
   logic [22:0] blink_cnt;
   logic [9:0] loss_cnt;
   logic loss_expired;
   logic wr;
   logic rd_ok;
   logic [31:0] next_rdata;

   // saturating clamp for parameter writes
   function automatic logic [12:0] clamp(input logic [31:0] v, input logic [12:0] lo,
                                         input logic [12:0] hi);
      if (v < {19'h0, lo}) begin
         clamp = lo;
      end else if (v > {19'h0, hi}) begin
         clamp = hi;
      end else begin
         clamp = v[12:0];
      end
   endfunction

   // single-pole filter, shift sets strength
   function automatic logic [25:0] filt_step(input logic [25:0] acc, input logic [11:0] x,
                                             input logic [3:0] sh);
      // settles at x shifted up by sh; setting 0 passes x straight through
      filt_step = acc - (acc >> sh) + {14'h0000, x};
   endfunction

   assign wr = psel_in && penable_in && pwrite_in;

   // parameter registers, clamped to their legal ranges
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         loss_holdoff_time <= rst_loss_holdoff;
         input_filter_level <= rst_filter;
         sleep_source_select <= rst_sleep_src;
         sleep_threshold <= rst_sleep_thr;
         wake_threshold <= rst_wake_thr;
         sleep_qualify_time <= rst_qual_time;
         wake_qualify_time <= rst_qual_time;
         safety_open_action <= 1'b0;
         safety_fault_reset_method <= 1'b0;
         param_write_mode <= 1'b0;
         cmd_status_layout_out <= 1'b0;
         serial_loss_action <= rst_loss_action;
         serial_loss_timeout <= rst_loss_timeout;
      end else if (wr) begin
         unique case (paddr_in)
            off_loss_holdoff: loss_holdoff_time <= 8'(clamp(pwdata_in, 13'h0,
                                                   {5'h0, max_loss_holdoff}));
            off_filter: input_filter_level <= 4'(clamp(pwdata_in, 13'h0,
                                                  {9'h0, max_filter}));
            off_sleep_src: sleep_source_select <= pwdata_in[1:0];
            off_sleep_thr: sleep_threshold <= 10'(clamp(pwdata_in, 13'h0,
                                                  {3'h0, max_level}));
            off_sleep_time: sleep_qualify_time <= clamp(pwdata_in, 13'h0, max_qual_time);
            off_wake_thr: wake_threshold <= 10'(clamp(pwdata_in, 13'h0, {3'h0, max_level}));
            off_wake_time: wake_qualify_time <= clamp(pwdata_in, 13'h0, max_qual_time);
            off_safety_cfg: begin
               safety_open_action <= pwdata_in[0];
               safety_fault_reset_method <= pwdata_in[1];
            end
            off_comm_cfg: begin
               param_write_mode <= pwdata_in[0];
               if (!io_connected_in) begin
                  cmd_status_layout_out <= pwdata_in[1];
               end
            end
            off_serial_cfg: begin
               serial_bit_rate <= 3'(clamp({29'h0, pwdata_in[2:0]}, 13'h0,
                                         {10'h0, max_bit_rate}));
               slave_node_address <= 8'(clamp({24'h0, pwdata_in[15:8]},
                                     {5'h0, min_node_addr}, {5'h0, max_node_addr}));
               serial_frame_format <= 3'(clamp({29'h0, pwdata_in[18:16]}, 13'h0,
                                             {10'h0, max_frame}));
               serial_loss_action <= pwdata_in[25:24];
            end
            off_loss_timeout: serial_loss_timeout <= 10'(clamp(pwdata_in,
                                {3'h0, min_loss_timeout}, {3'h0, max_loss_timeout}));
            default: begin
            end
         endcase
      end
   end

   // serial settings latched only at reset
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         active_rate <= serial_bit_rate;
         active_addr <= slave_node_address;
         active_frame <= serial_frame_format;
      end
   end

   // the 0.1 s time base
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || tick) begin
         tick_cnt <= 24'h000000;
      end else begin
         tick_cnt <= tick_cnt + 24'h000001;
      end
   end
   assign tick = (tick_cnt == 24'(tick_len - 1));

   // power-up hold-off for loss detection
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         holdoff_cnt <= 8'h00;
      end else if (tick && !holdoff_done) begin
         holdoff_cnt <= holdoff_cnt + 8'h01;
      end
   end
   assign holdoff_done = (holdoff_cnt >= loss_holdoff_time);

   // analog filters
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         volt_acc <= 26'h0;
         curr_acc <= 26'h0;
         volt_filt_out <= 12'h000;
         curr_filt_out <= 12'h000;
      end else begin
         volt_acc <= filt_step(volt_acc, volt_in, input_filter_level);
         curr_acc <= filt_step(curr_acc, curr_in, input_filter_level);
         volt_filt_out <= 12'(volt_acc >> input_filter_level);
         curr_filt_out <= 12'(curr_acc >> input_filter_level);
      end
   end

   // loss flags with hysteresis; held off early after power-up
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !holdoff_done) begin
         volt_loss_out <= 1'b0;
         curr_loss_out <= 1'b0;
      end else begin
         if (volt_in < v_loss_set) begin
            volt_loss_out <= 1'b1;
         end else if (volt_in > v_loss_clr) begin
            volt_loss_out <= 1'b0;
         end
         if (curr_in < i_loss_set) begin
            curr_loss_out <= 1'b1;
         end else if (curr_in > i_loss_clr) begin
            curr_loss_out <= 1'b0;
         end
      end
   end

   // compared signal and direction; inverted when sleep level above wake
   always_comb begin
      unique case (sleep_source_select)
         src_volt: sel_pct = volt_pct_in;
         src_curr: sel_pct = curr_pct_in;
         src_freq: sel_pct = cmd_freq_pct_in;
         default: sel_pct = 10'h000;
      endcase
      if (sleep_threshold > wake_threshold) begin
         sleep_cond = sel_pct > sleep_threshold;
         wake_cond = sel_pct < wake_threshold;
      end else begin
         sleep_cond = sel_pct < sleep_threshold;
         wake_cond = sel_pct > wake_threshold;
      end
   end

   // timers disarm on re-cross, restarting qualification
   duration_timer sleep_timer (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .arm_in(state == st_run && sleep_cond),
      .tick_in(tick),
      .length_in(sleep_qualify_time),
      .done_out(sleep_done)
   );
   duration_timer wake_timer (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .arm_in(state == st_sleep && wake_cond),
      .tick_in(tick),
      .length_in(wake_qualify_time),
      .done_out(wake_done)
   );

   // sleep state machine
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state <= st_idle;
      end else begin
         unique case (state)
            st_idle: if (running_in && sleep_source_select != src_off) begin
               state <= st_run;
            end
            st_run: begin
               if (!running_in || sleep_source_select == src_off) begin
                  state <= st_idle;
               end else if (sleep_done) begin
                  state <= st_sleep;
               end
            end
            st_sleep: begin
               if (!running_in || sleep_source_select == src_off) begin
                  state <= st_idle;
               end else if (wake_done) begin
                  state <= st_run;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // blink divider, about 2.4 Hz at 20 MHz
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         blink_cnt <= 23'h0;
      end else begin
         blink_cnt <= blink_cnt + 23'h1;
      end
   end
   assign asleep_out = (state == st_sleep);
   assign force_zero_freq_out = asleep_out;
   assign run_led_out = asleep_out ? blink_cnt[22] : running_in;

   // safety faults; set wins over any clear
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         safety_open_fault_out <= 1'b0;
         safety_hardware_fault_out <= 1'b0;
      end else begin
         if (!safety1_in && !safety2_in && !safety_open_action) begin
            safety_open_fault_out <= 1'b1;
         end else if (fault_clear_in) begin
            safety_open_fault_out <= 1'b0;
         end
         if (safety_hw_err_in) begin
            safety_hardware_fault_out <= 1'b1;
         end else if (fault_clear_in && safety_fault_reset_method) begin
            safety_hardware_fault_out <= 1'b0;
         end
      end
   end

   assign nv_commit_out = wr && !param_write_mode;

   // serial loss timer
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !serial_lost_in || !serial_controls_in) begin
         loss_cnt <= 10'h000;
      end else if (tick && !loss_expired) begin
         loss_cnt <= loss_cnt + 10'h001;
      end
   end
   assign loss_expired = (loss_cnt >= serial_loss_timeout);

   // loss actions, only while the serial port controls
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         serial_fault_out <= 1'b0;
         serial_coast_out <= 1'b0;
         serial_stop_out <= 1'b0;
         serial_hold_speed_out <= 1'b0;
      end else begin
         serial_fault_out <= loss_expired && serial_loss_action == act_fault;
         serial_coast_out <= loss_expired && serial_loss_action == act_coast;
         serial_stop_out <= loss_expired && serial_loss_action == act_stop;
         serial_hold_speed_out <= loss_expired && serial_loss_action == act_continue;
      end
   end

   // active serial settings
   always_comb begin
      unique case (active_rate)
         3'h0: bit_rate_out = 16'd1200;
         3'h1: bit_rate_out = 16'd2400;
         3'h2: bit_rate_out = 16'd4800;
         3'h4: bit_rate_out = 16'd19200;
         3'h5: bit_rate_out = 16'd38400;
         default: bit_rate_out = 16'd9600;
      endcase
   end
   assign slave_node_address_out = active_addr;
   assign parity_en_out = (active_frame != 3'h0) && (active_frame != 3'h3);
   assign parity_odd_out = (active_frame == 3'h2) || (active_frame == 3'h5);
   assign two_stop_out = (active_frame >= 3'h3);

   // apb read mux
   always_comb begin
      rd_ok = 1'b1;
      unique case (paddr_in)
         off_loss_holdoff: next_rdata = {24'h0, loss_holdoff_time};
         off_filter: next_rdata = {28'h0, input_filter_level};
         off_sleep_src: next_rdata = {30'h0, sleep_source_select};
         off_sleep_thr: next_rdata = {22'h0, sleep_threshold};
         off_sleep_time: next_rdata = {19'h0, sleep_qualify_time};
         off_wake_thr: next_rdata = {22'h0, wake_threshold};
         off_wake_time: next_rdata = {19'h0, wake_qualify_time};
         off_safety_cfg: next_rdata = {30'h0, safety_fault_reset_method, safety_open_action};
         off_comm_cfg: next_rdata = {30'h0, cmd_status_layout_out, param_write_mode};
         off_serial_cfg: next_rdata = {6'h0, serial_loss_action, 5'h0, serial_frame_format,
                                       slave_node_address, 5'h0, serial_bit_rate};
         off_loss_timeout: next_rdata = {22'h0, serial_loss_timeout};
         off_status: next_rdata = {24'h0, safety_hardware_fault_out, safety_open_fault_out,
                                   loss_expired, curr_loss_out, volt_loss_out,
                                   holdoff_done, asleep_out, state == st_run};
         off_serial_active: next_rdata = {13'h0, active_frame, active_addr, 5'h0,
                                          active_rate};
         default: begin
            next_rdata = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end

   // read data registered in setup, answered in access with no wait
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         prdata_out <= 32'h0;
      end else if (psel_in && !penable_in) begin
         prdata_out <= next_rdata;
      end
   end
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !rd_ok;
endmodule

//--- verification/field_source.sv
`timescale 1ns/1ps
// far side: analog sources plus the serial master's link state
module field_source (
   input wire logic [9:0] level_in,
   input wire logic link_up_in,
   output logic [11:0] volt_out,
   output logic [11:0] curr_out,
   output logic [9:0] pct_out,
   output logic lost_out
);
   // one level in 0.1 % drives both inputs; full scale is 4095
   assign volt_out = 12'((32'(level_in) * 4095) / 1000);
   assign curr_out = 12'((32'(level_in) * 4095) / 1000);
   assign pct_out = level_in;
   // a silent master shows as loss at once; the block does the timing
   assign lost_out = ~link_up_in;
endmodule

//--- verification/sleep_wake_assertions.sv
`timescale 1ns/1ps
// port watcher for the supervisor
module sleep_wake_assertions (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic safety1_in,
   input wire logic safety2_in,
   input wire logic fault_clear_in,
   input wire logic io_connected_in,
   input wire logic serial_controls_in,
   input wire logic serial_lost_in,
   input wire logic asleep_out,
   input wire logic force_zero_freq_out,
   input wire logic safety_open_fault_out,
   input wire logic safety_hardware_fault_out,
   input wire logic cmd_status_layout_out,
   input wire logic [7:0] slave_node_address_out,
   input wire logic serial_fault_out,
   input wire logic serial_coast_out,
   input wire logic serial_stop_out,
   input wire logic serial_hold_speed_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   wire logic [3:0] acts;
   // loss actions as one vector
   assign acts = {serial_fault_out, serial_coast_out, serial_stop_out, serial_hold_speed_out};
   a_zero_when_asleep: assert property (force_zero_freq_out == asleep_out)
      else $error("zero frequency does not follow sleep");
   a_layout_locked: assert property (io_connected_in |=> $stable(cmd_status_layout_out))
      else $error("layout changed while connected");
   a_addr_at_reset: assert property ($changed(slave_node_address_out) |-> $past(reset_in))
      else $error("node address changed outside reset");
   a_single_action: assert property ($onehot0(acts))
      else $error("more than one loss action");
   a_action_cause: assert property ($rose(|acts) |->
      $past(serial_controls_in, 2) && $past(serial_lost_in, 2))
      else $error("loss action without serial loss");
   a_open_cause: assert property ($rose(safety_open_fault_out) |->
      !$past(safety1_in) && !$past(safety2_in))
      else $error("open fault without both inputs off");
   a_hw_clear_cause: assert property ($fell(safety_hardware_fault_out) |->
      $past(fault_clear_in))
      else $error("hardware fault cleared without request");
   a_hw_sticky: assert property (safety_hardware_fault_out && !fault_clear_in |=>
      safety_hardware_fault_out)
      else $error("hardware fault dropped by itself");
   c_sleep: cover property ($rose(asleep_out));
   c_wake: cover property ($fell(asleep_out));
   c_action: cover property ($rose(|acts));
   c_hw_clear: cover property ($fell(safety_hardware_fault_out));
endmodule
bind sleep_wake_loss_supervisor sleep_wake_assertions chk (.sys_clk_in(sys_clk_in),
   .reset_in(reset_in), .safety1_in(safety1_in), .safety2_in(safety2_in),
   .fault_clear_in(fault_clear_in), .io_connected_in(io_connected_in),
   .serial_controls_in(serial_controls_in), .serial_lost_in(serial_lost_in),
   .asleep_out(asleep_out), .force_zero_freq_out(force_zero_freq_out),
   .safety_open_fault_out(safety_open_fault_out),
   .safety_hardware_fault_out(safety_hardware_fault_out),
   .cmd_status_layout_out(cmd_status_layout_out),
   .slave_node_address_out(slave_node_address_out),
   .serial_fault_out(serial_fault_out), .serial_coast_out(serial_coast_out),
   .serial_stop_out(serial_stop_out), .serial_hold_speed_out(serial_hold_speed_out));

//--- verification/sleep_wake_loss_supervisor_tb.sv
`timescale 1ns/1ps
module sleep_wake_loss_supervisor_tb;
   import sleep_wake_pkg::*;
   logic sys_clk_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0, e;
   logic running = 0, s1 = 1, s2 = 1, hw_err = 0, fclr = 0, io = 0, ctrl = 0, link = 1;
   logic [7:0] paddr = 0, node;
   logic [31:0] pwdata = 0, prdata, r;
   logic [9:0] level = 10'd500, pct;
   logic [11:0] volt, curr, vf;
   logic pready, pslverr, lost, asleep, vloss, closs, par_en, par_odd, two, open_f, hw_f, lay;
   logic [15:0] rate;
   wire logic [3:0] acts;
   int bad_count = 0, n_tests = 0, cyc = 0;
   int rates[6] = '{1200, 2400, 4800, 9600, 19200, 38400};
   // 50 ns clock
   initial begin
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   field_source src (.level_in(level), .link_up_in(link), .volt_out(volt), .curr_out(curr),
      .pct_out(pct), .lost_out(lost));
   sleep_wake_loss_supervisor #(.tick_len(10)) DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .volt_in(volt), .curr_in(curr), .cmd_freq_pct_in(pct), .volt_pct_in(pct),
      .curr_pct_in(pct), .running_in(running), .safety1_in(s1), .safety2_in(s2),
      .safety_hw_err_in(hw_err), .fault_clear_in(fclr), .io_connected_in(io),
      .serial_controls_in(ctrl), .serial_lost_in(lost), .volt_filt_out(vf), .curr_filt_out(),
      .volt_loss_out(vloss), .curr_loss_out(closs), .asleep_out(asleep), .force_zero_freq_out(),
      .run_led_out(), .safety_open_fault_out(open_f), .safety_hardware_fault_out(hw_f),
      .nv_commit_out(), .cmd_status_layout_out(lay), .bit_rate_out(rate),
      .slave_node_address_out(node), .parity_en_out(par_en), .parity_odd_out(par_odd),
      .two_stop_out(two), .serial_fault_out(acts[3]), .serial_coast_out(acts[2]),
      .serial_stop_out(acts[1]), .serial_hold_speed_out(acts[0]));
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   // one bus transfer; read data and error taken at the completing edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      wt(1);
      penable <= 1'b1;
      do wt(1); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      wt(1);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // reset doubles as the power cycle that applies serial settings
   task automatic rst();
      reset_in <= 1'b1;
      wt(2);
      reset_in <= 1'b0;
      wt(1);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // hang guard, far above the roughly 650 cycles the run needs
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      wt(20);
      reset_in <= 1'b0;
      wt(1);
      apb(1'b0, off_sleep_thr, 0); chk(r, 32'h64);
      apb(1'b0, off_wake_thr, 0); chk(r, 32'h96);
      apb(1'b0, off_loss_timeout, 0); chk(r, 32'h32);
      apb(1'b0, 8'h2c, 0); chk(e, 1);
      chk(rate, 32'd9600);
      chk(node, 32'd100);
      // every rate and frame code, applied only by the next reset
      for (int f = 0; f < 6; f++) begin
         apb(1'b1, off_serial_cfg, 32'((f << 16) | ((f == 5 ? 247 : 1) << 8) | f));
         chk(rate, 32'(f == 0 ? 9600 : rates[f - 1]));
         rst();
         chk(rate, 32'(rates[f]));
         chk(node, 32'(f == 5 ? 247 : 1));
         chk({par_en, par_odd, two}, {f % 3 != 0, f % 3 == 2, f >= 3});
      end
      // sleep and wake, normal then inverted levels
      apb(1'b1, off_sleep_src, 32'h1);
      apb(1'b1, off_sleep_time, 32'h2);
      apb(1'b1, off_wake_time, 32'h2);
      running <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         level <= m ? 10'd50 : 10'd500;
         apb(1'b1, off_sleep_thr, m ? 32'd200 : 32'd100);
         apb(1'b1, off_wake_thr, m ? 32'd100 : 32'd150);
         wt(40);
         level <= m ? 10'd500 : 10'd50;
         wt(5); chk(asleep, 0);
         wt(40); chk(asleep, 1);
         chk(vloss, m ? 0 : 1);
         chk(closs, m ? 0 : 1);
         chk(vf, volt);
         level <= m ? 10'd50 : 10'd500;
         wt(5); chk(asleep, 1);
         wt(40); chk(asleep, 0);
      end
      chk(vloss, 1);
      // loss ignored while the port does not control, then each action
      apb(1'b1, off_loss_timeout, 32'h3);
      link <= 1'b0;
      wt(60); chk(acts, 0);
      link <= 1'b1;
      ctrl <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         apb(1'b1, off_loss_timeout, 32'h3);
         apb(1'b1, off_serial_cfg, 32'(a << 24) | 32'h6403);
         link <= 1'b0;
         wt(5); chk(acts, 0);
         wt(40); chk(acts, 32'(4'h8 >> a));
         link <= 1'b1;
         rst();
      end
      // safety faults and layout lock
      s1 <= 1'b0;
      s2 <= 1'b0;
      wt(3); chk(open_f, 1);
      s1 <= 1'b1;
      hw_err <= 1'b1;
      wt(1);
      hw_err <= 1'b0;
      fclr <= 1'b1;
      wt(2);
      fclr <= 1'b0;
      wt(2); chk(hw_f, 1);
      apb(1'b1, off_safety_cfg, 32'h2);
      fclr <= 1'b1;
      wt(2);
      fclr <= 1'b0;
      wt(2); chk(hw_f, 0);
      io <= 1'b1;
      apb(1'b1, off_comm_cfg, 32'h2); chk(lay, 0);
      io <= 1'b0;
      apb(1'b1, off_comm_cfg, 32'h2); chk(lay, 1);
      complete_run();
   end
endmodule
